// *** hw/rtcc_core.sv ***
// Purpose: control, clock setting, day of week and interrupt timer
// Assumes: host strobes and oscillator are asynchronous and synchronised here
// Notes:   BCD time counters beyond hours are outside this block
`include "rtcc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module rtcc_core #(
   parameter int unsigned TICK_CYCLES = `RTCC_TICK_CYCLES,
   parameter int unsigned FAST_DIV    = 4
) (
   // Clock, reset, enable
   input  wire logic       i_clk,
   input  wire logic       i_nrst,
   input  wire logic       i_ce,
   // Register port
   input  wire logic       i_rd_n,
   input  wire logic       i_wr_n,
   input  wire logic [3:0] i_addr,
   input  wire logic [3:0] i_wdata,
   output logic [3:0]      o_rdata,
   // Oscillator and hours/rollover events from time counters
   input  wire logic       i_osc,
   input  wire logic       i_day_roll,
   input  wire logic       i_year_roll,
   input  wire logic [3:0] i_month,
   // Status to time counters
   output logic            o_set_pulse,
   output logic            o_tenths_clr,
   output logic [3:0]      o_dom_limit,
   output logic [5:0]      o_hours,
   // Interrupt pin
   output logic            o_int_out,
   output logic            o_int_oe
);
   initial begin
      if (TICK_CYCLES < 2 || FAST_DIV < 1) $error("rtcc_core: bad parameter");
   end

   ////////////////////////////////////////////////////////////////////////
   // Reset and input synchronisers
   logic rst_s1_ff, rst_n_ff;
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rst_s1_ff <= 1'b0;
         rst_n_ff  <= 1'b0;
      end else begin
         rst_s1_ff <= 1'b1;
         rst_n_ff  <= rst_s1_ff;
      end
   end

   logic [10:0] sy1_ff, sy2_ff;
   always_ff @(posedge i_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         sy1_ff <= 11'h000;
         sy2_ff <= 11'h000;
      end else if (i_ce) begin
         sy1_ff <= {~i_rd_n, ~i_wr_n, i_addr, i_wdata, i_osc};
         sy2_ff <= sy1_ff;
      end
   end
   rtcc_pkg::rtcc_bus_t bus;
   logic osc_s;
   assign bus   = sy2_ff[10:1];
   assign osc_s = sy2_ff[0];

   logic rd_d_ff, wr_d_ff;
   always_ff @(posedge i_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         rd_d_ff <= 1'b0;
         wr_d_ff <= 1'b0;
      end else if (i_ce) begin
         rd_d_ff <= bus.rd;
         wr_d_ff <= bus.wr;
      end
   end
   logic wr_evt, ctl_rd, ctl_rd_end;
   logic ctl_rd_q_ff;
   assign wr_evt     = bus.wr & ~wr_d_ff;
   assign ctl_rd     = bus.rd & (bus.addr == `RTCC_ADDR_CTRL);
   assign ctl_rd_end = rd_d_ff & ~bus.rd & ctl_rd_q_ff;
   always_ff @(posedge i_clk or negedge rst_n_ff) begin
      if (!rst_n_ff)  ctl_rd_q_ff <= 1'b0;
      else if (i_ce)  ctl_rd_q_ff <= ctl_rd;
   end

   ////////////////////////////////////////////////////////////////////////
   // Control latches
   rtcc_pkg::rtcc_ctrl_t ctrl_ff;
   rtcc_pkg::rtcc_cset_t cset_ff;
   rtcc_pkg::rtcc_irq_t  irq_ff;
   logic wr_ctl, wr_cset, wr_irq, irq_timeout;
   assign wr_ctl  = wr_evt & (bus.addr == `RTCC_ADDR_CTRL);                 // RULE12
   assign wr_cset = wr_evt & (bus.addr == `RTCC_ADDR_SETUP) & ~ctrl_ff.sel; // RULE2
   assign wr_irq  = wr_evt & (bus.addr == `RTCC_ADDR_SETUP) & ctrl_ff.sel;  // RULE2

   always_ff @(posedge i_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         ctrl_ff <= `RTCC_CTL_RESET;
      end else if (i_ce) begin
         if (wr_ctl)
            ctrl_ff <= bus.wdata;                                           // RULE12
         if (irq_ff.code == 3'h0)
            ctrl_ff.istop <= 1'b1;                                          // RULE10
         else if (irq_timeout && !irq_ff.repeat_mode && !wr_ctl)
            ctrl_ff.istop <= 1'b1;                                          // RULE15
      end
   end

   always_ff @(posedge i_clk or negedge rst_n_ff) begin
      if (!rst_n_ff)           irq_ff <= `RTCC_RESET_NIBBLE;
      else if (i_ce && wr_irq) irq_ff <= bus.wdata;                         // RULE8 RULE9
   end

   ////////////////////////////////////////////////////////////////////////
   // Setting pulse: 10 Hz, faster in test mode
   localparam int unsigned TW = $clog2(TICK_CYCLES);
   logic [TW-1:0] tick_cnt_ff;
   logic          set_pulse;
   assign set_pulse = (tick_cnt_ff == TW'(TICK_CYCLES - 1)) ||
                      (ctrl_ff.test && tick_cnt_ff >= TW'(FAST_DIV - 1));   // RULE16
   always_ff @(posedge i_clk or negedge rst_n_ff) begin
      if (!rst_n_ff)             tick_cnt_ff <= '0;
      else if (i_ce) begin
         if (ctrl_ff.cstop)      tick_cnt_ff <= '0;                          // RULE13
         else if (set_pulse)     tick_cnt_ff <= '0;                          // RULE23
         else                    tick_cnt_ff <= tick_cnt_ff + TW'(1);
      end
   end
   assign o_set_pulse  = set_pulse & ~ctrl_ff.cstop;                        // RULE23
   assign o_tenths_clr = ctrl_ff.cstop;                                     // RULE13

   ////////////////////////////////////////////////////////////////////////
   // Hours, AM/PM, clock setting register
   logic [5:0] hours_ff;
   logic       hour_roll, noon_step, mid_step;
   assign hour_roll = i_day_roll;
   function automatic logic [5:0] hr_next(input logic [5:0] h, input logic h24);
      if (h24) hr_next = (h == 6'd23) ? 6'd0 : h + 6'd1;                    // RULE6
      else     hr_next = (h == 6'd12) ? 6'd1 : h + 6'd1;                    // RULE6
   endfunction
   logic hr_tick;
   assign hr_tick   = o_set_pulse & hour_roll;
   assign noon_step = hr_tick & ~cset_ff.h24 & (hours_ff == 6'd11);
   assign mid_step  = hr_tick & (cset_ff.h24 ? hours_ff == 6'd23 :
                                 (hours_ff == 6'd11 && cset_ff.pm));
   always_ff @(posedge i_clk or negedge rst_n_ff) begin
      if (!rst_n_ff)      hours_ff <= 6'(`RTCC_HOUR12_RESET);
      else if (i_ce && hr_tick) hours_ff <= hr_next(hours_ff, cset_ff.h24);
   end
   assign o_hours = hours_ff;

   always_ff @(posedge i_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         cset_ff <= `RTCC_RESET_NIBBLE;
      end else if (i_ce) begin
         if (wr_cset) begin
            cset_ff <= bus.wdata;                                           // RULE3
            if (bus.wdata[`RTCC_CS_MODE_BIT])
               cset_ff.pm <= 1'b0;                                          // RULE5
         end else begin
            if (noon_step) cset_ff.pm <= ~cset_ff.pm;                       // RULE5
            if (cset_ff.h24) cset_ff.pm <= 1'b0;                            // RULE5
            if (o_set_pulse && i_year_roll)
               cset_ff.leap <= cset_ff.leap + 2'd1;                         // RULE4
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Day of week and month length
   logic [2:0] dow_ff;
   always_ff @(posedge i_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) dow_ff <= 3'h1;
      else if (i_ce) begin
         if (wr_evt && bus.addr == `RTCC_ADDR_DAY_WEEK) dow_ff <= bus.wdata[2:0];
         else if (mid_step) dow_ff <= (dow_ff == 3'h7) ? 3'h1 : dow_ff + 3'h1; // RULE1
      end
   end

   always_comb begin
      case (i_month)
         4'h2:                   o_dom_limit = (cset_ff.leap == 2'h0) ? 4'h9 : 4'h8; // RULE25
         4'h4, 4'h6, 4'h9, 4'hB: o_dom_limit = 4'h0;
         default:                o_dom_limit = 4'h1;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt timer: fixed tick grid keeps repeats locked
   function automatic logic [9:0] delay_ticks(input logic [2:0] c);
      case (c)
         3'h1:    delay_ticks = 10'd1;
         3'h2:    delay_ticks = 10'd5;
         3'h3:    delay_ticks = 10'd10;
         3'h4:    delay_ticks = 10'd50;
         3'h5:    delay_ticks = 10'd100;
         3'h6:    delay_ticks = 10'd300;
         3'h7:    delay_ticks = 10'd600;
         default: delay_ticks = 10'd0;
      endcase
   endfunction
   logic [TW-1:0] itick_ff;
   logic [9:0]    idly_ff;
   logic          itick;
   assign itick = (itick_ff == TW'(TICK_CYCLES - 1)) ||
                  (ctrl_ff.test && itick_ff >= TW'(FAST_DIV - 1));
   assign irq_timeout = ~ctrl_ff.istop & itick & (idly_ff == delay_ticks(irq_ff.code) - 10'd1);
   always_ff @(posedge i_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         itick_ff <= '0;
         idly_ff  <= '0;
      end else if (i_ce) begin
         if (ctrl_ff.istop || irq_ff.code == 3'h0) begin                    // RULE14
            itick_ff <= '0;
            idly_ff  <= '0;
         end else if (itick) begin
            itick_ff <= '0;
            idly_ff  <= irq_timeout ? 10'd0 : idly_ff + 10'd1;              // RULE11
         end else begin
            itick_ff <= itick_ff + TW'(1);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status flags
   logic dcf_ff, iflag_ff, ipend_ff;
   always_ff @(posedge i_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         dcf_ff   <= 1'b0;
         iflag_ff <= 1'b0;
         ipend_ff <= 1'b0;
      end else if (i_ce) begin
         if (ctl_rd_end)
            dcf_ff <= 1'b0;                                                 // RULE20
         else if (o_set_pulse && !ctl_rd_q_ff)
            dcf_ff <= 1'b1;                                                 // RULE18 RULE22
         if (irq_ff.code == 3'h0) begin
            iflag_ff <= 1'b0;                                               // RULE10
            ipend_ff <= 1'b0;
         end else if (ctl_rd_end) begin
            iflag_ff <= ipend_ff | irq_timeout;                             // RULE20 RULE21
            ipend_ff <= 1'b0;
         end else if (ctl_rd_q_ff || ctl_rd) begin
            if (irq_timeout) ipend_ff <= 1'b1;                              // RULE21
         end else if (irq_timeout || ipend_ff) begin
            iflag_ff <= 1'b1;                                               // RULE19
            ipend_ff <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data and interrupt pin
   always_ff @(posedge i_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) o_rdata <= 4'h0;
      else if (i_ce && bus.rd && !ctl_rd_q_ff) begin
         case (bus.addr)
            `RTCC_ADDR_CTRL:     o_rdata <= {dcf_ff, 2'b00, iflag_ff};      // RULE17 RULE20
            `RTCC_ADDR_SETUP:    o_rdata <= ctrl_ff.sel ? irq_ff : cset_ff; // RULE2 RULE3
            `RTCC_ADDR_DAY_WEEK: o_rdata <= {1'b0, dow_ff};
            default:             o_rdata <= 4'h0;
         endcase
      end
   end

   logic osc_mode;
   assign osc_mode  = ctrl_ff.test & (irq_ff.code == 3'h0);                 // RULE24
   assign o_int_out = osc_mode ? osc_s : 1'b0;                              // RULE26
   assign o_int_oe  = osc_mode | iflag_ff;                                  // RULE19 RULE26

   ////////////////////////////////////////////////////////////////////////
   // Checks
   chk_dow_range: assert property (@(posedge i_clk) disable iff (!rst_n_ff)
      dow_ff != 3'h0 || $past(wr_evt)) else $error("day of week zero"); // RULE1
   chk_pm_24h: assert property (@(posedge i_clk) disable iff (!rst_n_ff)
      cset_ff.h24 && !wr_cset |=> !cset_ff.pm) else $error("pm set in 24h"); // RULE5
   chk_zero_stop: assert property (@(posedge i_clk) disable iff (!rst_n_ff)
      i_ce && irq_ff.code == 3'h0 |=> ctrl_ff.istop && !iflag_ff) else $error("no stop"); // RULE10
   chk_int_pull: assert property (@(posedge i_clk) disable iff (!rst_n_ff)
      i_ce && irq_timeout && !ctl_rd && !ctl_rd_q_ff |=> o_int_oe && iflag_ff)
      else $error("timeout lost"); // RULE19
   chk_rd_hold: assert property (@(posedge i_clk) disable iff (!rst_n_ff)
      ctl_rd_q_ff && ctl_rd |=> $stable(iflag_ff)) else $error("flag moved in read"); // RULE20
   chk_dcf_clear: assert property (@(posedge i_clk) disable iff (!rst_n_ff)
      i_ce && ctl_rd_end |=> !dcf_ff) else $error("dcf not cleared"); // RULE18
   chk_single_stop: assert property (@(posedge i_clk) disable iff (!rst_n_ff)
      i_ce && irq_timeout && !irq_ff.repeat_mode && !wr_ctl |=> ctrl_ff.istop)
      else $error("single mode kept running"); // RULE15
   chk_stop_reset: assert property (@(posedge i_clk) disable iff (!rst_n_ff)
      i_ce && ctrl_ff.istop |=> idly_ff == 10'd0) else $error("timer not reset"); // RULE14
endmodule
`default_nettype wire

// *** common/rtcc_regs.svh ***
// Purpose: constants of the clock control and interrupt timer block
// Assumes: 4-bit register port, 10 MHz system clock
// Notes:   timing counts derive from the clock period
// Behaviour
// (RULE1) Day of week advances at midnight, counting 1..7 then back to 1.
// (RULE2) Address 15 reaches clock setting or interrupt register by select bit.
// (RULE3) Clock setting: leap count bits 3:2, AM/PM bit 1, hours mode bit 0.
// (RULE4) Leap field is two-bit counter stepped at new year; zero means leap year.
// (RULE5) AM/PM toggles at 11:59 to 12:00 in 12-hour mode; zero in 24-hour mode.
// (RULE6) Hours count 1..12 with mode bit 0, 0..23 with mode bit 1.
// (RULE7) Host changes hours mode and AM/PM in separate writes.
// (RULE8) Interrupt code 0 none; 1..7 select 0.1,0.5,1,5,10,30,60 seconds.
// (RULE9) Interrupt register bit 3 picks single (0) or repeated (1) mode.
// (RULE10) Zero interrupt register clears output and forces stop latch to 1.
// (RULE11) Delays exact within 1 ms; repeats stay locked to the first timeout.
// (RULE12) Address 0 write: test, clock stop, select, interrupt stop latches.
// (RULE13) Clock stop halts timekeeping and clears tenths; zero resumes.
// (RULE14) Interrupt stop resets timer; zero restarts with a full delay.
// (RULE15) Single mode stops timing at timeout; host restarts it by writing 0.
// (RULE16) Test latch selects test mode with accelerated counting.
// (RULE17) Address 0 read: data-changed on bit 3, zeros, interrupt flag bit 0.
// (RULE18) Data-changed set by each setting pulse outside a control read, cleared only by control read.
// (RULE19) Timeout sets interrupt flag and pulls interrupt low until control read.
// (RULE20) Flags latched during control read, cleared at its trailing edge.
// (RULE21) Timeout during control read is stored and shown after the read.
// (RULE22) Setting pulse during control read does not set data-changed.
// (RULE23) A 10 Hz setting pulse steps all counters and sets data-changed.
// (RULE24) Test mode with no interrupt drives oscillator onto interrupt pin.
// (RULE25) Days of month limited to 28, 29, 30 or 31 by month and leap count.
// (RULE26) Interrupt pin is open-drain pull-down; driven both ways only in test.
`ifndef RTCC_REGS_SVH
`define RTCC_REGS_SVH

`define RTCC_ADDR_CTRL      4'h0
`define RTCC_ADDR_TENTHS    4'h1
`define RTCC_ADDR_HR_UNITS  4'h6
`define RTCC_ADDR_HR_TENS   4'h7
`define RTCC_ADDR_DAY_WEEK  4'hE
`define RTCC_ADDR_SETUP     4'hF

`define RTCC_CTL_TEST_BIT   3
`define RTCC_CTL_CSTOP_BIT  2
`define RTCC_CTL_SEL_BIT    1
`define RTCC_CTL_ISTOP_BIT  0
`define RTCC_CTL_RESET      4'hF

`define RTCC_CS_MODE_BIT    0
`define RTCC_CS_PM_BIT      1
`define RTCC_CS_LEAP_LSB    2
`define RTCC_IR_REPEAT_BIT  3
`define RTCC_RESET_NIBBLE   4'h0
`define RTCC_HOUR12_RESET   4'h1

`define RTCC_CLK_NS         100
`define RTCC_TICK_NS        100000000
`define RTCC_TICK_CYCLES    (`RTCC_TICK_NS / `RTCC_CLK_NS)

`endif

// *** common/rtcc_pkg.sv ***
// Purpose: types of the clock control and interrupt timer block
// Assumes: used with rtcc_regs.svh
// Notes:   none
package rtcc_pkg;
   typedef struct packed {
      logic       test;
      logic       cstop;
      logic       sel;
      logic       istop;
   } rtcc_ctrl_t;

   typedef struct packed {
      logic [1:0] leap;
      logic       pm;
      logic       h24;
   } rtcc_cset_t;

   typedef struct packed {
      logic       repeat_mode;
      logic [2:0] code;
   } rtcc_irq_t;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [3:0] addr;
      logic [3:0] wdata;
   } rtcc_bus_t;
endpackage

// *** tb/rtcc_host.sv ***
// Purpose: host processor model driving the register strobes
// Assumes: write strobes held 4 cycles, read strobes for the caller's hold, at least 4 idle cycles between accesses
// Notes:   released address and data lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module rtcc_host (
   // Clock
   input  wire logic       i_clk,
   // Register port
   output logic            o_rd_n,
   output logic            o_wr_n,
   output logic [3:0]      o_addr,
   output logic [3:0]      o_wdata,
   input  wire logic [3:0] i_rdata
);
   initial begin
      o_rd_n  = 1'b1;
      o_wr_n  = 1'b1;
      o_addr  = 4'h0;
      o_wdata = 4'h0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Floating bus between accesses, then the minimum gap
   task automatic idle();
      o_addr  = ~o_addr;
      o_wdata = ~o_wdata;
      repeat (4) @(posedge i_clk);
      #1;
   endtask

   // One whole 4-bit word; mode and AM/PM are left to separate calls
   task automatic wr(input logic [3:0] a, input logic [3:0] v);
      o_addr  = a;
      o_wdata = v;
      o_wr_n  = 1'b0;
      repeat (4) @(posedge i_clk);
      #1;
      o_wr_n  = 1'b1;
      idle();
   endtask

   task automatic rd(input logic [3:0] a, input int hold, output logic [3:0] v);
      o_addr = a;
      o_rd_n = 1'b0;
      repeat (hold) @(posedge i_clk);
      #1;
      v      = i_rdata;
      o_rd_n = 1'b1;
      idle();
   endtask
endmodule
`default_nettype wire

// *** tb/test_rtcc_core.sv ***
// Purpose: self-checking bench of the clock control and interrupt timer
// Assumes: a tick of 20 cycles stands in for 100 ms
// Notes:   timeouts are measured from the start write within a short window
`timescale 1ns/1ps
`default_nettype none
`define CHK(e, a) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
   $display("[ERR] %0t exp %h got %h", $time, (e), (a)); end end
module test_rtcc_core;
   localparam int TK = 20;
   logic       clk = 1'b0;
   logic       nrst = 1'b0;
   logic       ce = 1'b1;
   logic       osc = 1'b0;
   logic       day_roll = 1'b0;
   logic       year_roll = 1'b0;
   logic [3:0] month = 4'h1;
   logic       rd_n, wr_n, set_pulse, tenths_clr, int_out, int_oe;
   logic [3:0] addr, wdata, rdata, dom_limit, d;
   logic [5:0] hours;
   logic [3:0] mo[3] = '{4'h2, 4'h4, 4'h1};
   logic [3:0] lim[3] = '{4'h9, 4'h0, 4'h1};
   int         dl[8] = '{0, 1, 5, 10, 50, 100, 300, 600};
   int         n_errors = 0;
   int         n_compared = 0;
   int         cyc = 0;
   int         t0 = 0;

   initial begin
      forever #50 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;

   rtcc_core #(.TICK_CYCLES(TK), .FAST_DIV(4)) dut (
      .i_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_rd_n(rd_n), .i_wr_n(wr_n),
      .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .i_osc(osc),
      .i_day_roll(day_roll), .i_year_roll(year_roll), .i_month(month),
      .o_set_pulse(set_pulse), .o_tenths_clr(tenths_clr), .o_dom_limit(dom_limit),
      .o_hours(hours), .o_int_out(int_out), .o_int_oe(int_oe));
   rtcc_host host (.i_clk(clk), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_addr(addr),
      .o_wdata(wdata), .i_rdata(rdata));

   ////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Wait for pin pulled low (sel 1) or a setting pulse (sel 0)
   task automatic wait_for(input int sel, input int lm, output int c);
      int n = 0;
      while (sel ? !(int_oe === 1'b1 && int_out === 1'b0) : (set_pulse !== 1'b1)) begin
         step(1);
         n++;
         if (n > lm) begin
            n_errors++;
            print_verdict();
         end
      end
      c = cyc - t0;
      step(1);
   endtask

   task automatic irq_at(input int tk);
      int n;
      wait_for(1, tk * TK + 40, n);
      `CHK(1'b1, (n >= tk * TK && n <= tk * TK + 8))
   endtask

   // Exactly one setting pulse with the rollover levels high
   task automatic roll(input logic y);
      int c;
      wait_for(0, 3 * TK, c);
      day_roll  = 1'b1;
      year_roll = y;
      wait_for(0, 3 * TK, c);
      day_roll  = 1'b0;
      year_roll = 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      int c1, c2;
      step(12);
      nrst = 1'b1;
      step(6);
      `CHK(1'b1, tenths_clr)
      `CHK(1'b1, int_oe)
      `CHK(6'h01, hours)
      host.rd(4'h0, 4, d);
      `CHK(4'h0, d & 4'h7)
      host.rd(4'hF, 4, d);
      `CHK(4'h0, d)
      host.wr(4'h0, 4'hB);
      `CHK(1'b1, int_oe)
      for (int i = 0; i < 2; i++) begin
         osc = ~osc;
         step(4);
         `CHK(osc, int_out)
      end
      wait_for(0, 3 * TK, c1);
      wait_for(0, 3 * TK, c2);
      `CHK(4, c2 - c1)
      host.wr(4'h0, 4'h3);
      `CHK(1'b0, tenths_clr)
      wait_for(0, 3 * TK, c1);
      wait_for(0, 3 * TK, c2);
      `CHK(TK, c2 - c1)
      `CHK(1'b0, int_oe)
      host.wr(4'h0, 4'h1);
      host.wr(4'hF, 4'h1);
      host.wr(4'hF, 4'hF);
      host.rd(4'hF, 4, d);
      `CHK(4'hD, d)
      roll(1'b1);
      host.rd(4'hF, 4, d);
      `CHK(4'h1, d)
      for (int i = 0; i < 3; i++) begin
         month = mo[i];
         step(3);
         `CHK(lim[i], dom_limit)
      end
      host.wr(4'hF, 4'h5);
      month = 4'h2;
      step(3);
      `CHK(4'h8, dom_limit)
      host.wr(4'hE, 4'h7);
      repeat (22) roll(1'b0);
      `CHK(6'h00, hours)
      host.rd(4'hE, 4, d);
      `CHK(4'h1, d)
      host.wr(4'h2, 4'h9);
      host.rd(4'h2, 4, d);
      `CHK(4'h0, d)
      host.rd(4'hE, 4, d);
      host.rd(4'h0, 4, d);
      `CHK(1'b1, d[3])
      host.wr(4'h0, 4'h5);
      host.rd(4'h0, 4, d);
      host.rd(4'h0, 4, d);
      `CHK(4'h0, d)
      for (int c = 1; c < 8; c++) begin
         host.wr(4'h0, 4'h3);
         host.wr(4'hF, {1'b1, c[2:0]});
         t0 = cyc;
         host.wr(4'h0, 4'h2);
         irq_at(dl[c]);
         host.rd(4'h0, 4, d);
         `CHK(1'b1, d[0])
         `CHK(1'b0, int_oe)
         irq_at(2 * dl[c]);
         host.rd(4'h0, 4, d);
      end
      host.wr(4'h0, 4'h3);
      host.wr(4'hF, 4'h1);
      t0 = cyc;
      host.wr(4'h0, 4'h2);
      irq_at(1);
      host.rd(4'h0, 4, d);
      step(3 * TK);
      `CHK(1'b0, int_oe)
      t0 = cyc;
      host.wr(4'h0, 4'h2);
      irq_at(1);
      host.rd(4'h0, 4, d);
      host.wr(4'h0, 4'h2);
      host.wr(4'h0, 4'h3);
      step(TK);
      `CHK(1'b0, int_oe)
      t0 = cyc;
      host.wr(4'h0, 4'h2);
      irq_at(1);
      host.rd(4'h0, 4, d);
      host.wr(4'h0, 4'h2);
      host.wr(4'hF, 4'h0);
      host.wr(4'hF, 4'h1);
      step(3 * TK);
      `CHK(1'b0, int_oe)
      host.wr(4'hF, 4'h9);
      t0 = cyc;
      host.wr(4'h0, 4'h2);
      irq_at(1);
      host.rd(4'h0, 4, d);
      host.rd(4'h0, 20, d);
      `CHK(1'b0, d[0])
      `CHK(1'b1, int_oe)
      host.rd(4'h0, 4, d);
      `CHK(1'b1, d[0])
      host.wr(4'h0, 4'h3);
      print_verdict();
   end
endmodule
`default_nettype wire
